// [logic/flash_protect_and_reset.sv]
`timescale 1ns/10ps
// Summary of operation
// R01: main protect status, bit per sector
// R02: secondary protect bits 0-3, 4-6 unused
// R03: bit 7 reports security lock set
// R04: program/erase to protected sector ignored
// R05: reset command is one bus write
// R06: reset also accepted after unlock pair
// R07: host resets after status or id read
// R08: host resets when error bit rises
// R09: reset ignored during program or bulk erase
// R10: slow variant recovers within milliseconds
// R11: slow variant aborts sector erase, milliseconds
// R12: fast variant immediate, 25us on error
// R13: fast variant aborts sector erase, 25us
// R14: reset pin aborts, 25us if busy
// R15: reset pulse held at least 25us
// R16: sram enabled only while select high
// R17: sram select uses two product terms
// R18: battery indicator on port c pin four
// R19: sector and sram selects from decode array
// R20: writes never alter protect or security flags
`include "flash_protect_regs.svh"

module flash_protect_and_reset
    import flash_protect_pkg::*;
#(
    parameter int MAIN_SECTORS = 8,
    parameter int SEC_SECTORS = 4,
    parameter int FAST_CYC = `RESET_FAST_CYC,
    parameter int SLOW_CYC = `RESET_SLOW_CYC,
    parameter logic [15:0] SRAM_T0_MATCH = 16'h8000,
    parameter logic [15:0] SRAM_T0_MASK = 16'hF800,
    parameter logic [15:0] SRAM_T1_MATCH = 16'h0000,
    parameter logic [15:0] SRAM_T1_MASK = 16'h0000,
    parameter logic SRAM_T1_EN = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device bus from the host mcu
    input wire logic bus_wr,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_data,
    input wire logic bus_psen_b,
    // protect flags from the programming path
    input wire logic [MAIN_SECTORS-1:0] main_prot_in,
    input wire logic [SEC_SECTORS-1:0] sec_prot_in,
    input wire logic security_in,
    input wire logic prot_load,
    // flash engine status
    input wire logic start_program,
    input wire logic start_bulk_erase,
    input wire logic start_sector_erase,
    input wire logic op_done,
    input wire logic error_status_bit,
    // external reset pin, active low
    input wire logic reset_pin_b,
    // power monitor
    input wire logic supply_below_battery,
    // decoded selects
    input wire logic [MAIN_SECTORS-1:0] main_sector_hit,
    input wire logic [SEC_SECTORS-1:0] sec_sector_hit,
    output logic [MAIN_SECTORS-1:0] main_sector_select,
    output logic [SEC_SECTORS-1:0] secondary_sector_select,
    output logic sram_select,
    output logic sram_enable,
    output logic op_accept,
    output logic flash_abort,
    output logic read_mode,
    output logic port_c_pin_four
);

    logic [MAIN_SECTORS-1:0] main_prot_r;
    logic [SEC_SECTORS-1:0] sec_prot_r;
    logic security_r;
    logic fast_mode_r;
    logic vbat_en_r;
    logic reset_pin_d_r;
    flash_state_t state_r;
    unlock_state_t unlock_r;
    logic [31:0] recover_cnt_r;
    logic reset_cmd;
    logic pin_pulse;
    logic busy;
    logic pin_abort;
    logic pin_restart;
    logic any_request;
    logic target_prot;
    logic [MAIN_SECTORS-1:0] main_blocked;
    logic [SEC_SECTORS-1:0] sec_blocked;
    logic [31:0] recover_load;
    logic sram_term0;
    logic sram_term1;
    logic apb_wr;
    logic apb_rd;
    logic [7:0] sec_reg;
    logic [31:0] rdata_nxt;

    assign pready = 1'b1;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !pwrite;

    // protect flags: only the programming path loads them
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            main_prot_r <= '0;
            sec_prot_r <= '0;
            security_r <= 1'b0;
        end else if (prot_load) begin // see R20
            main_prot_r <= main_prot_in;
            sec_prot_r <= sec_prot_in;
            security_r <= security_in;
        end
    end

    // control register
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            fast_mode_r <= 1'b1;
            vbat_en_r <= 1'b0;
        end else if (apb_wr && paddr == `CTRL_ADDR) begin
            fast_mode_r <= pwdata[`CTRL_FAST_BIT];
            vbat_en_r <= pwdata[`CTRL_VBAT_EN_BIT];
        end
    end

    always_comb begin
        sec_reg = '0;
        sec_reg[`SEC_PROT_MSB:`SEC_PROT_LSB] = sec_prot_r[3:0]; // see R02
        sec_reg[`SEC_SECURITY_BIT] = security_r; // see R03
    end

    always_comb begin
        rdata_nxt = '0;
        pslverr = 1'b0;
        unique case (paddr)
            `MAIN_PROT_ADDR: rdata_nxt[MAIN_SECTORS-1:0] = main_prot_r; // see R01
            `SEC_PROT_ADDR: rdata_nxt[7:0] = sec_reg;
            `CTRL_ADDR: begin
                rdata_nxt[`CTRL_FAST_BIT] = fast_mode_r;
                rdata_nxt[`CTRL_VBAT_EN_BIT] = vbat_en_r;
            end
            `STATUS_ADDR: begin
                rdata_nxt[`STAT_STATE_MSB:`STAT_STATE_LSB] = state_r;
                rdata_nxt[`STAT_ERR_BIT] = error_status_bit;
                rdata_nxt[`STAT_READ_BIT] = read_mode;
                rdata_nxt[`STAT_UNLOCK_MSB:`STAT_UNLOCK_LSB] = unlock_r;
            end
            `PROT_IMAGE_ADDR: rdata_nxt[15:0] = {sec_reg, main_prot_r};
            default: pslverr = psel && penable;
        endcase
    end

    // read data registered in setup phase, valid in access phase
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            prdata <= '0;
        end else if (apb_rd && !penable) begin
            prdata <= rdata_nxt;
        end
    end

    // unlock sequence tracker
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            unlock_r <= UL_IDLE;
        end else if (bus_wr) begin
            unique case (unlock_r)
                UL_IDLE: unlock_r <= (bus_addr[11:0] == `UNLOCK1_ADDR
                    && bus_data == `UNLOCK1_DATA) ? UL_FIRST : UL_IDLE;
                UL_FIRST: unlock_r <= (bus_addr[11:0] == `UNLOCK2_ADDR
                    && bus_data == `UNLOCK2_DATA) ? UL_SECOND : UL_IDLE;
                UL_SECOND: unlock_r <= UL_IDLE;
            endcase
        end
    end

    // single write, with or without the unlock pair ahead
    assign reset_cmd = bus_wr && bus_data == `RESET_CMD_DATA; // see R05, R06
    assign pin_pulse = reset_pin_d_r && !reset_pin_b;

    // program or erase in flight
    assign busy = state_r == ST_PROGRAM || state_r == ST_BULK_ERASE
        || state_r == ST_SECTOR_ERASE;
    // a fresh pin pulse during recovery must not cut the wait short
    assign pin_abort = !reset_pin_b && busy;
    assign pin_restart = pin_pulse && state_r == ST_RECOVER;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reset_pin_d_r <= 1'b1;
        end else begin
            reset_pin_d_r <= reset_pin_b;
        end
    end

    // per sector: a request aimed at a protected sector
    for (genvar i = 0; i < MAIN_SECTORS; i++) begin : g_main_block
        assign main_blocked[i] = main_sector_hit[i] && main_prot_r[i];
    end

    for (genvar j = 0; j < SEC_SECTORS; j++) begin : g_sec_block
        assign sec_blocked[j] = sec_sector_hit[j] && sec_prot_r[j];
    end

    assign target_prot = |main_blocked || |sec_blocked;
    assign any_request = start_program || start_bulk_erase || start_sector_erase;
    // no new operation starts while the reset pin is held low
    assign op_accept = read_mode && !target_prot && any_request; // see R04
    // recovery length for the selected variant
    assign recover_load = fast_mode_r ? 32'(FAST_CYC) : 32'(SLOW_CYC);

    // flash operation and recovery sequencer
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_r <= ST_READ;
            recover_cnt_r <= '0;
            flash_abort <= 1'b0;
        end else begin
            flash_abort <= 1'b0;
            if (pin_abort) begin
                state_r <= ST_RECOVER; // see R14
                recover_cnt_r <= 32'(FAST_CYC);
                flash_abort <= 1'b1;
            end else if (pin_restart && recover_cnt_r < 32'(FAST_CYC)) begin
                recover_cnt_r <= 32'(FAST_CYC); // see R14
            end else begin
                unique case (state_r)
                    ST_READ: begin
                        if (op_accept && start_program) begin
                            state_r <= ST_PROGRAM;
                        end else if (op_accept && start_bulk_erase) begin
                            state_r <= ST_BULK_ERASE;
                        end else if (op_accept) begin
                            state_r <= ST_SECTOR_ERASE;
                        end else if (reset_cmd && error_status_bit) begin
                            state_r <= ST_RECOVER; // see R12
                            recover_cnt_r <= recover_load;
                        end else if (reset_cmd && !fast_mode_r) begin
                            state_r <= ST_RECOVER; // see R10
                            recover_cnt_r <= 32'(SLOW_CYC);
                        end
                    end
                    ST_PROGRAM, ST_BULK_ERASE: begin
                        if (op_done) begin // see R09
                            state_r <= ST_READ;
                        end
                    end
                    ST_SECTOR_ERASE: begin
                        if (reset_cmd) begin
                            state_r <= ST_RECOVER; // see R11, R13
                            recover_cnt_r <= recover_load;
                            flash_abort <= 1'b1;
                        end else if (op_done) begin
                            state_r <= ST_READ;
                        end
                    end
                    ST_RECOVER: begin
                        if (recover_cnt_r <= 32'd1) begin
                            state_r <= ST_READ;
                            recover_cnt_r <= '0;
                        end else begin
                            recover_cnt_r <= recover_cnt_r - 32'd1;
                        end
                    end
                    default: state_r <= ST_READ;
                endcase
            end
        end
    end

    assign read_mode = state_r == ST_READ && reset_pin_b;

    // decode array: two product terms over address, only the second also gated by psen strobe
    assign sram_term0 = (bus_addr & SRAM_T0_MASK) == SRAM_T0_MATCH; // see R17
    assign sram_term1 = SRAM_T1_EN && (bus_addr & SRAM_T1_MASK) == SRAM_T1_MATCH
        && bus_psen_b; // see R17
    assign sram_select = sram_term0 || sram_term1;

    // sram has priority over flash, secondary over main
    assign secondary_sector_select = sram_select ? '0 : sec_sector_hit; // see R19
    assign main_sector_select = (sram_select || |sec_sector_hit) ? '0 : main_sector_hit;
    assign sram_enable = sram_select; // see R16

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            port_c_pin_four <= 1'b0;
        end else begin
            port_c_pin_four <= vbat_en_r && supply_below_battery; // see R18
        end
    end

endmodule

// [logic/flash_protect_regs.svh]
`ifndef FLASH_PROTECT_REGS_SVH
`define FLASH_PROTECT_REGS_SVH

// apb register byte addresses
`define MAIN_PROT_ADDR 12'h000
`define SEC_PROT_ADDR 12'h004
`define CTRL_ADDR 12'h008
`define STATUS_ADDR 12'h00C
`define PROT_IMAGE_ADDR 12'h010
// unlock / command encodings on the device bus
`define UNLOCK1_ADDR 12'h555
`define UNLOCK1_DATA 8'hAA
`define UNLOCK2_ADDR 12'hAAA
`define UNLOCK2_DATA 8'h55
`define RESET_CMD_DATA 8'hF0
// field positions
`define SEC_SECURITY_BIT 7
`define SEC_PROT_LSB 0
`define SEC_PROT_MSB 3
`define CTRL_FAST_BIT 0
`define CTRL_VBAT_EN_BIT 1
`define STAT_STATE_LSB 0
`define STAT_STATE_MSB 2
`define STAT_ERR_BIT 3
`define STAT_READ_BIT 4
`define STAT_UNLOCK_LSB 5
`define STAT_UNLOCK_MSB 6
// timing
`define CLK_MHZ 40
`define RESET_FAST_US 25
`define RESET_SLOW_US 2000
`define RESET_FAST_CYC (`RESET_FAST_US * `CLK_MHZ)
`define RESET_SLOW_CYC (`RESET_SLOW_US * `CLK_MHZ)
`define PROT_RESET 8'h00

`endif

// [logic/flash_protect_pkg.sv]
package flash_protect_pkg;
    typedef enum logic [2:0] {
        ST_READ,
        ST_PROGRAM,
        ST_BULK_ERASE,
        ST_SECTOR_ERASE,
        ST_RECOVER
    } flash_state_t;

    typedef enum logic [1:0] {
        UL_IDLE,
        UL_FIRST,
        UL_SECOND
    } unlock_state_t;
endpackage

// [verif/flash_protect_and_reset_properties.sv]
`timescale 1ns/10ps
module flash_protect_and_reset_properties #(
    parameter int MAIN_SECTORS = 8,
    parameter int SEC_SECTORS = 4,
    parameter int FAST_CYC = 20,
    parameter int SLOW_CYC = 50
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pslverr,
    input wire logic start_program,
    input wire logic start_bulk_erase,
    input wire logic start_sector_erase,
    input wire logic op_accept,
    input wire logic flash_abort,
    input wire logic read_mode,
    input wire logic reset_pin_b,
    input wire logic supply_below_battery,
    input wire logic port_c_pin_four,
    input wire logic sram_select,
    input wire logic sram_enable,
    input wire logic [MAIN_SECTORS-1:0] main_sector_select,
    input wire logic [SEC_SECTORS-1:0] secondary_sector_select
);
    localparam int LIM = SLOW_CYC + 2 * FAST_CYC + 8;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_mains;
        !supply_below_battery [*2];
    endsequence
    AST_SRAM_EN: assert property (sram_enable |-> sram_select)
        else $error("sram enabled without select");
    AST_SRAM_PRIO: assert property (sram_select |-> !(|main_sector_select)
        && !(|secondary_sector_select))
        else $error("sector select beside sram");
    AST_SEC_PRIO: assert property ((|secondary_sector_select) |-> !(|main_sector_select))
        else $error("main select beside secondary");
    AST_PIN_LOW: assert property (!reset_pin_b |-> !read_mode)
        else $error("read mode while pin low");
    AST_ABORT_PULSE: assert property (flash_abort |=> !flash_abort)
        else $error("abort longer than one cycle");
    AST_RECOVER: assert property (flash_abort |-> ##[1:LIM] read_mode)
        else $error("no return to read mode");
    AST_BAT_ON: assert property (port_c_pin_four |-> $past(supply_below_battery))
        else $error("battery flag without battery");
    AST_BAT_OFF: assert property (s_mains |-> !port_c_pin_four)
        else $error("battery flag on mains");
    AST_ACCEPT: assert property (op_accept |-> reset_pin_b
        && (start_program || start_bulk_erase || start_sector_erase))
        else $error("accept without request");
    AST_PROT_WR: assert property (s_acc ##0 (pwrite && paddr inside {12'h000, 12'h004})
        |-> !pslverr)
        else $error("status write refused");
    AST_UNMAPPED: assert property (s_acc ##0 !(paddr inside {12'h000, 12'h004, 12'h008,
        12'h00c, 12'h010}) |-> pslverr)
        else $error("unmapped access accepted");
endmodule

// [verif/host_mcu_model.sv]
`timescale 1ns/10ps
module host_mcu_model (
    input wire logic core_clk,
    output logic bus_wr,
    output logic [15:0] bus_addr,
    output logic [7:0] bus_data,
    output logic bus_psen_b
);
    initial begin
        bus_wr = 0;
        bus_addr = 16'h5a5a;
        bus_data = 8'ha5;
        bus_psen_b = 1;
    end
    // one write strobe, bus inverted once released
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus_wr <= 1;
        bus_addr <= a;
        bus_data <= d;
        @(posedge core_clk);
        bus_wr <= 0;
        bus_addr <= ~a;
        bus_data <= ~d;
        @(posedge core_clk);
    endtask
    task automatic cmd(input logic ul);
        if (ul) begin
            wr(16'h0555, 8'haa);
            wr(16'h0aaa, 8'h55);
        end
        wr(16'h4321, 8'hf0);
    endtask
    task automatic rd(input logic [15:0] a);
        bus_addr <= a;
        bus_psen_b <= 0;
        @(posedge core_clk);
    endtask
endmodule

// [verif/flash_protect_and_reset_test.sv]
`timescale 1ns/10ps
module flash_protect_and_reset_test;
    localparam int FC = 20;
    localparam int SC = 50;
    logic core_clk = 0;
    logic rst_b = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, x;
    wire logic bus_wr, bus_psen_b;
    wire logic [15:0] bus_addr;
    wire logic [7:0] bus_data;
    logic [7:0] main_prot_in = '0;
    logic [7:0] main_sector_hit = '0;
    logic [7:0] main_sector_select;
    logic [3:0] sec_prot_in = '0;
    logic [3:0] sec_sector_hit = '0;
    logic [3:0] secondary_sector_select;
    logic security_in = 0;
    logic prot_load = 0;
    logic op_done = 0;
    logic error_status_bit = 0;
    logic reset_pin_b = 1;
    logic supply_below_battery = 0;
    logic [2:0] st = '0;
    wire logic start_program = st[0];
    wire logic start_bulk_erase = st[1];
    wire logic start_sector_erase = st[2];
    logic sram_select, sram_enable, op_accept, flash_abort, read_mode, port_c_pin_four;
    int errors = 0;
    int compares = 0;
    int ab_n = 0;
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (flash_abort === 1'b1) ab_n++;
    flash_protect_and_reset #(.FAST_CYC(FC), .SLOW_CYC(SC)) u_dut (.*);
    host_mcu_model u_h (.*);
    task automatic cmp(input string s, input logic [31:0] v, input logic [31:0] g);
        compares++;
        if (g !== v) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", s, v, g);
        end
    endtask
    task automatic results;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        cmp("pready", 1, pready);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1)
            results();
        else
            @(posedge core_clk);
    endtask
    task automatic wrm(input int lim);
        int n;
        n = 0;
        while (read_mode !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        cmp("read_mode", 1, read_mode);
        if (read_mode !== 1'b1)
            results();
    endtask
    task automatic go(input int k, input logic v);
        st <= 3'b001 << k;
        @(negedge core_clk);
        cmp("op_accept", v, op_accept);
        @(posedge core_clk);
        st <= 0;
        @(posedge core_clk);
    endtask
    task automatic ld(input logic [7:0] m, input logic [3:0] s, input logic c);
        main_prot_in <= m;
        sec_prot_in <= s;
        security_in <= c;
        prot_load <= 1;
        @(posedge core_clk);
        prot_load <= 0;
        @(posedge core_clk);
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        cmp("timeout", 0, 1);
        results();
    end
    initial begin
        logic [7:0] m;
        logic [3:0] s;
        logic c;
        logic [15:0] a;
        int base;
        void'($urandom(32'hdcba_1ffb));
        repeat (16) @(posedge core_clk);
        rst_b <= 1;
        @(posedge core_clk);
        repeat (4) begin
            m = 8'($urandom);
            s = 4'($urandom);
            c = 1'($urandom);
            ld(m, s, c);
            apb(0, 12'h000, 0);
            cmp("main_prot", m, q[7:0]);
            apb(0, 12'h004, 0);
            cmp("sec_prot", {c, s}, {q[7], q[3:0]});
            cmp("sec_unused", 0, q[6:4]);
            apb(1, 12'h000, $urandom);
            apb(1, 12'h004, $urandom);
            apb(0, 12'h000, 0);
            cmp("main_keep", m, q[7:0]);
            apb(0, 12'h004, 0);
            cmp("sec_keep", {c, s}, {q[7], q[3:0]});
            apb(0, 12'h010, 0);
            cmp("image", {c, 3'h0, s, m}, q[15:0]);
            u_h.cmd(1'($urandom));
        end
        apb(0, 12'h0fc, 0);
        cmp("slverr", 1, e);
        ld(8'h01, 4'h1, 0);
        main_sector_hit <= 8'h01;
        go(0, 0);
        main_sector_hit <= 8'h00;
        sec_sector_hit <= 4'h1;
        go(2, 0);
        sec_sector_hit <= 4'h0;
        main_sector_hit <= 8'h02;
        for (int k = 0; k < 2; k++) begin
            go(k, 1);
            base = ab_n;
            u_h.cmd(1);
            repeat (4) @(posedge core_clk);
            cmp("no_abort", base, ab_n);
            op_done <= 1;
            @(posedge core_clk);
            op_done <= 0;
            @(posedge core_clk);
        end
        for (int k = 0; k < 2; k++) begin
            apb(1, 12'h008, k ? 0 : 1);
            go(2, 1);
            base = ab_n;
            u_h.cmd(!k);
            repeat (4) @(posedge core_clk);
            cmp("abort", base + 1, ab_n);
            wrm(k ? SC + 8 : FC + 8);
        end
        apb(1, 12'h008, 1);
        error_status_bit <= 1;
        u_h.cmd(0);
        cmp("rm_err", 0, read_mode);
        wrm(FC + 8);
        error_status_bit <= 0;
        u_h.cmd(0);
        cmp("rm_fast", 1, read_mode);
        go(0, 1);
        base = ab_n;
        reset_pin_b <= 0;
        repeat (FC) @(posedge core_clk);
        reset_pin_b <= 1;
        cmp("pin_abort", base + 1, ab_n);
        wrm(FC + 8);
        apb(0, 12'h00c, 0);
        cmp("status_rm", 1, q[4]);
        for (int k = 0; k < 2; k++) begin
            apb(1, 12'h008, k ? 3 : 1);
            apb(0, 12'h008, 0);
            cmp("ctrl", k ? 3 : 1, q[1:0]);
            supply_below_battery <= 1;
            repeat (3) @(posedge core_clk);
            cmp("vbat", k, port_c_pin_four);
            supply_below_battery <= 0;
            repeat (3) @(posedge core_clk);
            cmp("vbat_off", 0, port_c_pin_four);
        end
        for (int i = 0; i < 12; i++) begin
            a = i == 0 ? 16'h87ff : i == 1 ? 16'h8800 : i == 2 ? 16'h8000 : 16'($urandom);
            x = (a & 16'hf800) == 16'h8000;
            main_sector_hit <= 8'($urandom);
            sec_sector_hit <= 4'($urandom);
            u_h.rd(a);
            @(negedge core_clk);
            cmp("sram_sel", x, sram_select);
            cmp("sram_en", x, sram_enable);
            cmp("sec_sel", x ? 0 : sec_sector_hit, secondary_sector_select);
            cmp("main_sel", (x || |sec_sector_hit) ? 0 : main_sector_hit,
                main_sector_select);
            @(posedge core_clk);
        end
        results();
    end
endmodule
bind flash_protect_and_reset flash_protect_and_reset_properties #(.MAIN_SECTORS(MAIN_SECTORS),
    .SEC_SECTORS(SEC_SECTORS), .FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC)) u_chk (.*);
